// File: design/sogc_pkg.sv
// Package: register map, field layout, reset values and range checks of the correction block
package sogc_pkg;

  // ----------------------------------------------------------------
  // Byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN_C_LO = 8'h14;
  localparam logic [7:0] ADDR_GAIN_C_HI = 8'h15;
  localparam logic [7:0] ADDR_GAIN_S_LO = 8'h16;
  localparam logic [7:0] ADDR_GAIN_S_HI = 8'h17;
  localparam logic [7:0] ADDR_OFF_C_LO = 8'h18;
  localparam logic [7:0] ADDR_OFF_C_HI = 8'h19;
  localparam logic [7:0] ADDR_OFF_S_LO = 8'h1a;
  localparam logic [7:0] ADDR_OFF_S_HI = 8'h1b;
  localparam logic [7:0] ADDR_RAW = 8'h24;
  localparam logic [7:0] ADDR_CORR = 8'h28;
  localparam logic [7:0] ADDR_ANGLE_A = 8'h2c;
  localparam logic [7:0] ADDR_ANGLE_B = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_MASK = 8'h38;
  localparam logic [7:0] ADDR_CONTROL = 8'h3c;

  // ----------------------------------------------------------------
  // Field widths, positions and reset values
  // ----------------------------------------------------------------
  localparam int OFF_W = 13;
  localparam int GAIN_W = 11;
  localparam int SAMP_W = 16;
  localparam int MAG_W = 14;
  localparam int GAIN_SHIFT = 11;
  localparam int FIELD_HI_POS = 16;
  localparam logic [OFF_W-1:0] OFF_RESET = 13'h0000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 11'h400;
  localparam logic [GAIN_W+1:0] GAIN_HALF = 13'h0400;
  localparam logic signed [OFF_W-1:0] OFF_MIN = -13'sd2730;
  localparam logic signed [OFF_W-1:0] OFF_MAX = 13'sd2729;
  localparam logic [MAG_W-1:0] MAG_MAX = 14'h3fff;

  // Status bits, one per event
  localparam int STAT_W = 4;
  localparam int STAT_COS_OFF_ERR = 0;
  localparam int STAT_SIN_OFF_ERR = 1;
  localparam int STAT_SIN_SAT = 2;
  localparam int STAT_COS_SAT = 3;
  localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;
  localparam int CTRL_DISABLE_POS = 0;

  // Accepted offset correction range
  function automatic logic sogc_off_ok(input logic [OFF_W-1:0] v);
    sogc_off_ok = ($signed(v) >= OFF_MIN) && ($signed(v) <= OFF_MAX);
  endfunction

endpackage

// File: design/sogc_corr_if.sv
// Interface: one channel of raw sample, correction values and corrected result
`timescale 1ns/1ps
`default_nettype none
interface sogc_corr_if;
  logic [15:0] raw;
  logic [12:0] offset;
  logic [10:0] gain;
  logic sign_bit;
  logic [13:0] mag;
  logic sat;
  modport calc (input raw, input offset, input gain, output sign_bit, output mag, output sat);
  modport user (output raw, output offset, output gain, input sign_bit, input mag, input sat);
endinterface
`default_nettype wire

// File: design/sogc_corr.sv
// Module: offset and gain correction of one channel into sign and magnitude
`timescale 1ns/1ps
`default_nettype none
module sogc_corr (
  sogc_corr_if.calc ch
);

  logic signed [17:0] sum;
  logic signed [13:0] gain_full;
  logic signed [31:0] prod;
  logic [31:0] prod_abs;
  logic [20:0] mag_wide;

  // ----------------------------------------------------------------
  // (2*raw + offset) * (1024 + gain) / 2048
  // ----------------------------------------------------------------
  always_comb begin
    // One spare bit, so an out-of-range sample plus offset cannot wrap the sum
    sum = $signed({ch.raw[15], ch.raw, 1'b0}) + $signed({{5{ch.offset[12]}}, ch.offset});
    gain_full = $signed({1'b0, sogc_pkg::GAIN_HALF + {2'b00, ch.gain}});
    prod = sum * gain_full;
    // Magnitude taken before the shift, so truncation is toward zero on both signs
    prod_abs = prod[31] ? 32'(-prod) : prod;
    mag_wide = prod_abs[sogc_pkg::GAIN_SHIFT +: 21];
    ch.sat = |mag_wide[20:sogc_pkg::MAG_W];
    ch.mag = ch.sat ? sogc_pkg::MAG_MAX : mag_wide[13:0];
    // A zero result is reported as positive
    ch.sign_bit = prod[31] && (ch.mag != 14'h0000);
  end

endmodule // sogc_corr
`default_nettype wire

// File: design/sogc_top.sv
// Top: correction datapath and register view of the sine/cosine readout
`timescale 1ns/1ps
`default_nettype none
module sogc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic samp_valid,
  input wire logic [15:0] samp_sin,
  input wire logic [15:0] samp_cos,
  input wire logic [15:0] angle_in,
  input wire logic ctl_update,
  input wire logic [12:0] ctl_offset_sin,
  input wire logic [12:0] ctl_offset_cos,
  input wire logic [10:0] ctl_gain_sin,
  input wire logic [10:0] ctl_gain_cos,
  output logic controller_disable,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [12:0] sine_offset_corr, next_sine_offset_corr;
  logic [12:0] cosine_offset_corr, next_cosine_offset_corr;
  logic [10:0] sine_gain_corr, next_sine_gain_corr;
  logic [10:0] cosine_gain_corr, next_cosine_gain_corr;
  logic [7:0] stage_off_sin, next_stage_off_sin;
  logic [7:0] stage_off_cos, next_stage_off_cos;
  logic [7:0] stage_gain_sin, next_stage_gain_sin;
  logic [7:0] stage_gain_cos, next_stage_gain_cos;
  logic [15:0] raw_sin, next_raw_sin;
  logic [15:0] raw_cos, next_raw_cos;
  logic [15:0] corr_sin, next_corr_sin;
  logic [15:0] corr_cos, next_corr_cos;
  logic [15:0] angle_value, next_angle_value;
  logic [3:0] status, next_status;
  logic [3:0] mask, next_mask;
  logic next_controller_disable;
  logic next_irq;
  logic [31:0] next_rd_data;

  logic [12:0] wr_off;
  logic [10:0] wr_gain;
  logic [3:0] events;
  logic ctl_active;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Upper write byte over the staged low byte gives the whole field
  function automatic logic [12:0] join_off(input logic [7:0] hi, input logic [7:0] lo);
    join_off = {hi[4:0], lo};
  endfunction

  function automatic logic [10:0] join_gain(input logic [7:0] hi, input logic [7:0] lo);
    join_gain = {hi[2:0], lo};
  endfunction

  // ----------------------------------------------------------------
  // Correction channels
  // ----------------------------------------------------------------
  sogc_corr_if sin_ch ();
  sogc_corr_if cos_ch ();

  assign sin_ch.raw = raw_sin;
  assign sin_ch.offset = sine_offset_corr;
  assign sin_ch.gain = sine_gain_corr;
  assign cos_ch.raw = raw_cos;
  assign cos_ch.offset = cosine_offset_corr;
  assign cos_ch.gain = cosine_gain_corr;

  sogc_corr u_corr_sin (
    .ch(sin_ch.calc)
  );

  sogc_corr u_corr_cos (
    .ch(cos_ch.calc)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_sine_offset_corr = sine_offset_corr;
    next_cosine_offset_corr = cosine_offset_corr;
    next_sine_gain_corr = sine_gain_corr;
    next_cosine_gain_corr = cosine_gain_corr;
    next_stage_off_sin = stage_off_sin;
    next_stage_off_cos = stage_off_cos;
    next_stage_gain_sin = stage_gain_sin;
    next_stage_gain_cos = stage_gain_cos;
    next_mask = mask;
    next_controller_disable = controller_disable;
    events = 4'h0;
    wr_off = join_off(wr_data, stage_off_cos);
    wr_gain = join_gain(wr_data, stage_gain_cos);
    ctl_active = !controller_disable;

    if (wr_en) begin
      case (addr)
        sogc_pkg::ADDR_OFF_C_LO: begin
          next_stage_off_cos = wr_data;
        end
        sogc_pkg::ADDR_OFF_C_HI: begin
          wr_off = join_off(wr_data, stage_off_cos);
          // A software write changes the whole field only here (the controller loads it whole), so a half-written value never reaches the datapath
          if (sogc_pkg::sogc_off_ok(wr_off)) begin
            next_cosine_offset_corr = wr_off;
          end else begin
            events[sogc_pkg::STAT_COS_OFF_ERR] = 1'b1;
          end
        end
        sogc_pkg::ADDR_OFF_S_LO: begin
          next_stage_off_sin = wr_data;
        end
        sogc_pkg::ADDR_OFF_S_HI: begin
          wr_off = join_off(wr_data, stage_off_sin);
          if (sogc_pkg::sogc_off_ok(wr_off)) begin
            next_sine_offset_corr = wr_off;
          end else begin
            events[sogc_pkg::STAT_SIN_OFF_ERR] = 1'b1;
          end
        end
        sogc_pkg::ADDR_GAIN_C_LO: begin
          next_stage_gain_cos = wr_data;
        end
        sogc_pkg::ADDR_GAIN_C_HI: begin
          wr_gain = join_gain(wr_data, stage_gain_cos);
          next_cosine_gain_corr = wr_gain;
        end
        sogc_pkg::ADDR_GAIN_S_LO: begin
          next_stage_gain_sin = wr_data;
        end
        sogc_pkg::ADDR_GAIN_S_HI: begin
          wr_gain = join_gain(wr_data, stage_gain_sin);
          next_sine_gain_corr = wr_gain;
        end
        sogc_pkg::ADDR_MASK: begin
          next_mask = wr_data[3:0];
        end
        sogc_pkg::ADDR_CONTROL: begin
          next_controller_disable = wr_data[sogc_pkg::CTRL_DISABLE_POS];
        end
        default: begin
        end
      endcase
    end

    // The controller's value wins over a software write in the same cycle
    if (ctl_active && ctl_update) begin
      next_sine_offset_corr = ctl_offset_sin;
      next_cosine_offset_corr = ctl_offset_cos;
      next_sine_gain_corr = ctl_gain_sin;
      next_cosine_gain_corr = ctl_gain_cos;
    end

    // Sample capture and result registers
    next_raw_sin = samp_valid ? samp_sin : raw_sin;
    next_raw_cos = samp_valid ? samp_cos : raw_cos;
    next_corr_sin = {sin_ch.sign_bit, 1'b0, sin_ch.mag};
    next_corr_cos = {cos_ch.sign_bit, 1'b0, cos_ch.mag};
    next_angle_value = angle_in;
    events[sogc_pkg::STAT_SIN_SAT] = sin_ch.sat;
    events[sogc_pkg::STAT_COS_SAT] = cos_ch.sat;

  end

  // ----------------------------------------------------------------
  // Status and interrupt: next values
  // ----------------------------------------------------------------
  always_comb begin
    // Sticky status, write one to clear; a new event beats the clear
    next_status = status;
    if (wr_en && (addr == sogc_pkg::ADDR_STATUS)) begin
      next_status = status & ~wr_data[3:0];
    end
    next_status = next_status | events;
    next_irq = |(next_status & next_mask);
  end

  // ----------------------------------------------------------------
  // Read port: next value
  // ----------------------------------------------------------------
  always_comb begin
    // Data valid only in the cycle after the strobe
    next_rd_data = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        sogc_pkg::ADDR_GAIN_C_LO: begin
          next_rd_data = {5'h00, sine_gain_corr, 5'h00, cosine_gain_corr};
        end
        sogc_pkg::ADDR_OFF_C_LO: begin
          next_rd_data = {3'h0, sine_offset_corr, 3'h0, cosine_offset_corr};
        end
        sogc_pkg::ADDR_RAW: begin
          next_rd_data = {raw_sin, raw_cos};
        end
        sogc_pkg::ADDR_CORR: begin
          next_rd_data = {corr_sin, corr_cos};
        end
        sogc_pkg::ADDR_ANGLE_A, sogc_pkg::ADDR_ANGLE_B: begin
          next_rd_data = {16'h0000, angle_value};
        end
        sogc_pkg::ADDR_STATUS: begin
          next_rd_data = {28'h0000000, status};
        end
        sogc_pkg::ADDR_MASK: begin
          next_rd_data = {28'h0000000, mask};
        end
        sogc_pkg::ADDR_CONTROL: begin
          next_rd_data = {31'h0, controller_disable};
        end
        default: begin
          next_rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sine_offset_corr <= sogc_pkg::OFF_RESET;
      cosine_offset_corr <= sogc_pkg::OFF_RESET;
      sine_gain_corr <= sogc_pkg::GAIN_RESET;
      cosine_gain_corr <= sogc_pkg::GAIN_RESET;
      stage_off_sin <= 8'h00;
      stage_off_cos <= 8'h00;
      stage_gain_sin <= 8'h00;
      stage_gain_cos <= 8'h00;
      raw_sin <= 16'h0000;
      raw_cos <= 16'h0000;
      corr_sin <= 16'h0000;
      corr_cos <= 16'h0000;
      angle_value <= 16'h0000;
      mask <= sogc_pkg::MASK_RESET;
      controller_disable <= 1'b0;
    end else begin
      sine_offset_corr <= next_sine_offset_corr;
      cosine_offset_corr <= next_cosine_offset_corr;
      sine_gain_corr <= next_sine_gain_corr;
      cosine_gain_corr <= next_cosine_gain_corr;
      stage_off_sin <= next_stage_off_sin;
      stage_off_cos <= next_stage_off_cos;
      stage_gain_sin <= next_stage_gain_sin;
      stage_gain_cos <= next_stage_gain_cos;
      raw_sin <= next_raw_sin;
      raw_cos <= next_raw_cos;
      corr_sin <= next_corr_sin;
      corr_cos <= next_corr_cos;
      angle_value <= next_angle_value;
      mask <= next_mask;
      controller_disable <= next_controller_disable;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= sogc_pkg::STAT_RESET;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule // sogc_top
`default_nettype wire

// File: bench/sogc_asserts.sv
// Checker: port-level properties of the correction block
`timescale 1ns/1ps
`default_nettype none
module sogc_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic samp_valid,
  input wire logic [15:0] samp_sin,
  input wire logic [15:0] samp_cos,
  input wire logic [15:0] angle_in,
  input wire logic controller_disable,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Access sequences
  // ----------------------------------------
  sequence s_rd(logic [7:0] a);
    rd_en && addr == a;
  endsequence
  sequence s_samp_rd;
    samp_valid ##1 !samp_valid ##0 s_rd(8'h24);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RESET_OUT: assert property ($past(rst) |->
    !controller_disable && !irq && rd_data == 32'h0) else $error("outputs not clear after reset");
  AST_DIS_SET: assert property (wr_en && addr == 8'h3c && wr_data[0] |=> controller_disable)
    else $error("controller disable not set");
  AST_DIS_HOLD: assert property (!($past(wr_en) && $past(addr) == 8'h3c) |->
    $stable(controller_disable)) else $error("controller disable moved without write");
  AST_RAW_RD: assert property (s_samp_rd |=>
    rd_data == {$past(samp_sin, 2), $past(samp_cos, 2)}) else $error("raw sample readback wrong");
  AST_ANGLE_RD: assert property ((s_rd(8'h2c) or s_rd(8'h30)) |=>
    rd_data == {16'h0, $past(angle_in, 2)}) else $error("angle readback wrong");
  AST_CORR_ZERO: assert property (s_rd(8'h28) |=> !rd_data[30] && !rd_data[14])
    else $error("corrected zero bits set");
  AST_CORR_SIGN: assert property (s_rd(8'h28) |=>
    !(rd_data[31] && rd_data[29:16] == 14'h0) && !(rd_data[15] && rd_data[13:0] == 14'h0))
    else $error("negative sign with zero magnitude");
  AST_OFF_ZERO: assert property (s_rd(8'h18) |=>
    rd_data[31:29] == 3'h0 && rd_data[15:13] == 3'h0) else $error("offset spare bits set");
endmodule // sogc_asserts
`default_nettype wire

// File: bench/sogc_adc_model.sv
// Partner model: sensor sample source feeding the raw sample inputs
`timescale 1ns/1ps
`default_nettype none
module sogc_adc_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [15:0] sin_in,
  input wire logic [15:0] cos_in,
  output logic samp_valid,
  output logic [15:0] samp_sin,
  output logic [15:0] samp_cos
);
  // Outside a sample the lines toggle, so a stale capture cannot pass for a fresh one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      samp_valid <= 1'b0;
      samp_sin <= 16'h0;
      samp_cos <= 16'h0;
    end else begin
      samp_valid <= go;
      samp_sin <= go ? sin_in : ~samp_sin;
      samp_cos <= go ? cos_in : ~samp_cos;
    end
  end
endmodule // sogc_adc_model
`default_nettype wire

// File: bench/sogc_top_tb.sv
// Testbench: register and datapath tests of the correction block
`timescale 1ns/1ps
`default_nettype none
module sogc_top_tb;
  logic clk_sys, samp_valid, controller_disable, irq;
  logic rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, go = 1'b0, ctl_update = 1'b0;
  logic [7:0] addr = 8'h0, wr_data = 8'h0;
  logic [31:0] rd_data;
  logic [15:0] samp_sin, samp_cos, ms = 16'h0, mc = 16'h0, angle_in = 16'h1234;
  logic [12:0] ctl_offset_sin = 13'h0, ctl_offset_cos = 13'h0;
  logic [10:0] ctl_gain_sin = 11'h400, ctl_gain_cos = 11'h400;
  int failures = 0, num_checks = 0;
  // Row 2 feeds samples beyond the converter range, so both magnitudes must saturate
  int cs[4][6] = '{'{-4096, 4095, 0, 0, 1024, 1024}, '{-4096, 4095, -2730, 2729, 2047, 0},
    '{32767, -32768, 0, 0, 1024, 1024}, '{1, 0, -3, 0, 0, 0}};
  sogc_top uut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .samp_valid(samp_valid), .samp_sin(samp_sin),
    .samp_cos(samp_cos), .angle_in(angle_in), .ctl_update(ctl_update),
    .ctl_offset_sin(ctl_offset_sin), .ctl_offset_cos(ctl_offset_cos),
    .ctl_gain_sin(ctl_gain_sin), .ctl_gain_cos(ctl_gain_cos),
    .controller_disable(controller_disable), .irq(irq));
  sogc_adc_model adc (.clk_sys(clk_sys), .rst(rst), .go(go), .sin_in(ms), .cos_in(mc),
    .samp_valid(samp_valid), .samp_sin(samp_sin), .samp_cos(samp_cos));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobe stays up so writes can run back to back; the next task drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic idle(input int n);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic setcorr(input int os, input int oc, input int gs, input int gc);
    wr(8'h18, oc[7:0]);
    wr(8'h19, {3'h0, oc[12:8]});
    wr(8'h1a, os[7:0]);
    wr(8'h1b, {3'h0, os[12:8]});
    wr(8'h14, gc[7:0]);
    wr(8'h15, {5'h0, gc[10:8]});
    wr(8'h16, gs[7:0]);
    wr(8'h17, {5'h0, gs[10:8]});
  endtask
  task automatic samp(input int s, input int c);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    go <= 1'b1;
    ms <= s[15:0];
    mc <= c[15:0];
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic ctl(input logic [12:0] os, input logic [12:0] oc, input logic [10:0] gs,
    input logic [10:0] gc);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    ctl_offset_sin <= os;
    ctl_offset_cos <= oc;
    ctl_gain_sin <= gs;
    ctl_gain_cos <= gc;
    ctl_update <= 1'b1;
    @(posedge clk_sys);
    ctl_update <= 1'b0;
  endtask
  // Integer division truncates toward zero, as the magnitude does
  function automatic logic [15:0] cf(input int r, input int o, input int g);
    int v;
    int m;
    v = (2 * r + o) * (1024 + g) / 2048;
    m = (v < 0) ? -v : v;
    cf = {v < 0, 1'b0, (m > 16383) ? 14'h3fff : m[13:0]};
  endfunction
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #40000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h18, 32'h0);
    rd(8'h3c, 32'h0);
    rd(8'h40, 32'h0);
    setcorr(2729, -2730, 1024, 1024);
    rd(8'h18, 32'h0aa91556);
    rd(8'h14, 32'h04000400);
    wr(8'h18, 8'haa);
    wr(8'h19, 8'h0a);
    wr(8'h1a, 8'h55);
    wr(8'h1b, 8'h15);
    rd(8'h18, 32'h0aa91556);
    rd(8'h34, 32'h3);
    wr(8'h38, 8'h02);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(8'h34, 8'h02);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h34, 32'h1);
    wr(8'h38, 8'h00);
    $display("test offset registers done");
    ctl(13'h0100, 13'h1f00, 11'h123, 11'h456);
    rd(8'h18, 32'h01001f00);
    rd(8'h14, 32'h01230456);
    wr(8'h3c, 8'h01);
    rd(8'h3c, 32'h1);
    ctl(13'h0, 13'h0, 11'h0, 11'h0);
    rd(8'h18, 32'h01001f00);
    rd(8'h14, 32'h01230456);
    $display("test controller done");
    for (int i = 0; i < 4; i++) begin
      setcorr(cs[i][2], cs[i][3], cs[i][4], cs[i][5]);
      samp(cs[i][0], cs[i][1]);
      rd(8'h24, {cs[i][0][15:0], cs[i][1][15:0]});
      rd(8'h28, {cf(cs[i][0], cs[i][2], cs[i][4]), cf(cs[i][1], cs[i][3], cs[i][5])});
    end
    rd(8'h34, 32'h0000000d);
    wr(8'h24, 8'hff);
    wr(8'h28, 8'hff);
    wr(8'h2c, 8'h00);
    rd(8'h24, 32'h00010000);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h1234);
    @(posedge clk_sys);
    angle_in <= 16'hbeef;
    rd(8'h30, 32'h0000beef);
    $display("test datapath done");
    stop_test();
  end
endmodule // sogc_top_tb
bind sogc_top sogc_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .samp_valid(samp_valid),
  .samp_sin(samp_sin), .samp_cos(samp_cos), .angle_in(angle_in),
  .controller_disable(controller_disable), .irq(irq));
`default_nettype wire
